// >>> rtl/psc_pkg.sv
// package: constants, register map and types of the protection switch control
package psc_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SECOND_NS = 1000000000;
  localparam int TICKS_PER_SECOND_DEF = SECOND_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 24;
  localparam logic [3:0] LENIENT_FRAMES = 4'hA;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  localparam logic [5:0] MAX_REVERT_SEC = 6'h3C;
  localparam logic [5:0] LOCAL_REVERT_SEC = 6'h0F;
  // pin synchroniser idle value: {ovr_n[1:0], remote_sel, local_sw[5:0]}
  localparam logic [8:0] PIN_RESET = 9'h180;

  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_SWITCH_CFG = 8'h00;
  localparam logic [7:0] REG_DETECT_CFG = 8'h04;
  localparam logic [7:0] REG_COMMAND = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_EFFECTIVE = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // switch configuration fields
  localparam int SW_AUTO_BIT = 0;
  localparam int SW_REVERT_BIT = 1;
  localparam int SW_SECTEST_BIT = 2;
  localparam int SW_HOLD_LSB = 8;
  localparam int SW_OVR_LSB = 16;
  localparam logic [31:0] SW_RESET = 32'h00010F07;
  localparam logic [31:0] SW_MASK = 32'h00033F07;

  // detector configuration fields
  localparam int DET_TRS_LSB = 0;
  localparam int DET_EDH_LSB = 2;
  localparam int DET_AUD_BIT = 4;
  localparam int DET_BLK_BIT = 5;
  localparam int DET_FRZ_LSB = 6;
  localparam int DET_GRP_LSB = 8;
  localparam int DET_THR_LSB = 10;
  localparam int DET_CH_LSB = 12;
  localparam logic [31:0] DET_RESET = 32'h00003835;
  localparam logic [31:0] DET_MASK = 32'h0000FFFF;

  // command and status bits
  localparam int CMD_PRI_BIT = 0;
  localparam int CMD_SEC_BIT = 1;
  localparam int CMD_LOCAL_BIT = 2;
  localparam int STAT_POS = 0;
  localparam int STAT_PRI_GOOD = 1;
  localparam int STAT_SEC_GOOD = 2;
  localparam int STAT_REMOTE_SEL = 3;
  localparam int STAT_LOADED = 4;
  localparam int STAT_PRI_FAULT = 5;
  localparam int STAT_SEC_FAULT = 6;
  localparam int STAT_READY = 7;

  typedef enum logic [1:0] {TEST_OFF = 2'h0, TEST_LENIENT = 2'h1, TEST_STRICT = 2'h2} psc_test_type;
  typedef enum logic [1:0] {FRZ_OFF = 2'h0, FRZ_CLEAN = 2'h1, FRZ_NOISY = 2'h2} psc_freeze_type;
  typedef enum logic [1:0] {
    OVR_OFF = 2'h0, OVR_EDGE = 2'h1, OVR_FAULT_LOW = 2'h2, OVR_INHIBIT_LOW = 2'h3
  } psc_ovr_type;
  typedef enum logic [1:0] {
    THR_20DB = 2'h0, THR_30DB = 2'h1, THR_38DB = 2'h2, THR_46DB = 2'h3
  } psc_thr_type;
  typedef enum logic [1:0] {SEL_PRI = 2'h1, SEL_SEC = 2'h2} psc_state_type;

  typedef struct packed {
    logic auto_switch;
    logic auto_revert;
    logic sec_test;
    logic [5:0] revert_sec;
    psc_ovr_type ovr_mode;
    psc_test_type trs;
    psc_test_type edh;
    logic audio_en;
    logic black_en;
    psc_freeze_type freeze;
    logic [1:0] audio_group;
    psc_thr_type audio_thr;
    logic [3:0] audio_ch_en;
  } psc_cfg_type;

  localparam logic [1:0] GROUP_DEF = 2'h0;
  localparam logic [3:0] CH_EN_DEF = 4'h3;
  localparam psc_cfg_type CFG_DEFAULT = '{
    auto_switch: 1'b1, auto_revert: 1'b1, sec_test: 1'b1,
    revert_sec: LOCAL_REVERT_SEC, ovr_mode: OVR_EDGE,
    trs: TEST_LENIENT, edh: TEST_LENIENT, audio_en: 1'b1, black_en: 1'b1,
    freeze: FRZ_OFF, audio_group: GROUP_DEF, audio_thr: THR_38DB,
    audio_ch_en: CH_EN_DEF};

endpackage : psc_pkg

// >>> rtl/psc_pin_if.sv
// interface: synchronised front-edge and control-connector pins
`timescale 1ns/1ps
`default_nettype none
interface psc_pin_if;
  logic [1:0] ovr_level_n;
  logic [1:0] ovr_fall;
  logic remote_sel;
  logic [5:0] local_sw;
  modport src (output ovr_level_n, ovr_fall, remote_sel, local_sw);
  modport dst (input ovr_level_n, ovr_fall, remote_sel, local_sw);
endinterface : psc_pin_if
`default_nettype wire

// >>> rtl/psc_pin_sync.sv
// module: two-stage pin synchroniser and override falling-edge detector
`timescale 1ns/1ps
`default_nettype none
module psc_pin_sync
  import psc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] ovr_n,
  input wire logic remote_sel,
  input wire logic [5:0] local_sw,
  psc_pin_if.src pins
);

  logic [8:0] meta;
  logic [8:0] stable;
  logic [1:0] ovr_prev;
  logic [8:0] next_meta;
  logic [8:0] next_stable;
  logic [1:0] next_ovr_prev;

  always_comb
  begin
    next_meta = {ovr_n, remote_sel, local_sw};
    next_stable = meta;
    next_ovr_prev = stable[8:7];
  end

  // idle-high reset on the override pins so release makes no false edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= PIN_RESET;
      stable <= PIN_RESET;
      ovr_prev <= 2'h3;
    end
    else
    begin
      meta <= next_meta;
      stable <= next_stable;
      ovr_prev <= next_ovr_prev;
    end
  end

  assign pins.ovr_level_n = stable[8:7];
  assign pins.ovr_fall = ovr_prev & ~stable[8:7]; // R01 R19
  assign pins.remote_sel = stable[6];
  assign pins.local_sw = stable[5:0];

  a_fall_single: assert property (@(posedge aclk) disable iff (!aresetn) // R19
    (pins.ovr_fall != 2'h0) |=> ((pins.ovr_fall & $past(pins.ovr_fall)) == 2'h0))
    else $error("override edge lasted more than one cycle");
  a_fall_cause: assert property (@(posedge aclk) disable iff (!aresetn) // R01
    pins.ovr_fall[0] |-> ($past(pins.ovr_level_n[0]) && !pins.ovr_level_n[0]))
    else $error("override event without a high-to-low transition");

endmodule : psc_pin_sync
`default_nettype wire

// >>> rtl/psc_switch_control.sv
// module: protection switch control with AXI4-Lite registers
// Notes on behaviour
// (R01) override acts only on high-to-low transitions; fault and inhibit modes act on override 0 held low
// (R02) override 0 forces primary, 1 secondary
// (R03) primary override returns output regardless of revert
// (R04) primary relay energized only while primary good
// (R05) secondary relay energized only while secondary good
// (R06) position relay de-energized means primary selected
// (R07) relays not asserted good report failure
// (R08) selector pin picks remote or local configuration
// (R09) remotely written parameters replace local switches
// (R10) local mode: unswitched parameters take defaults
// (R11) remote parameters kept in own storage
// (R12) override behaviour: off, edge, fault, inhibit
// (R13) audio group one of four, default one
// (R14) silence threshold four levels, default -38 dB
// (R15) per-channel audio enables, default 1,2 on
// (R16) auto switch only when secondary not faulted
// (R17) auto revert after primary good hold time
// (R18) lenient checks fault after ten error frames
// (R19) override pins synchronised, one-cycle edge events
// (R20) reset: primary, relays off, defaults applied
`timescale 1ns/1ps
`default_nettype none
module psc_switch_control
  import psc_pkg::*;
#(
  parameter int unsigned TICKS_PER_SECOND = TICKS_PER_SECOND_DEF
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] ovr_n,
  input wire logic remote_sel,
  input wire logic [5:0] local_sw,
  input wire logic frame_tick,
  input wire logic [1:0] trs_err,
  input wire logic [1:0] edh_err,
  input wire logic [1:0] audio_bad,
  input wire logic [1:0] black_bad,
  input wire logic [1:0] freeze_bad,
  output psc_cfg_type det_cfg,
  output logic relay_pri_good,
  output logic relay_sec_good,
  output logic relay_sec_selected,
  output logic pri_alarm
);

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICKS_PER_SECOND - 1);

  logic aw_held, w_held, bvalid, rvalid;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [ADDR_W-1:0] awaddr_q, next_awaddr_q;
  logic [31:0] wdata_q, next_wdata_q, rdata, next_rdata, rd_word;
  logic [3:0] wstrb_q, next_wstrb_q;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic aw_take, w_take, ar_take, do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_cmd, cmd_pri, cmd_sec, cmd_local;
  logic [31:0] sw_word, next_sw_word, det_word, next_det_word;
  logic loaded, next_loaded;
  logic [1:0] settle, next_settle;
  logic ready;
  psc_cfg_type cfg, next_cfg, local_cfg;
  wire [1:0] input_fault;
  logic pri_fault, sec_fault, ext_fault, inhibit, edge_mode;
  logic force_pri, force_sec, revert_due;
  psc_state_type state, next_state;
  logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
  logic [5:0] hold_sec, next_hold_sec;
  logic next_relay_pri, next_relay_sec, next_alarm;

  psc_pin_if pins ();

  psc_pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ovr_n(ovr_n),
    .remote_sel(remote_sel),
    .local_sw(local_sw),
    .pins(pins)
  );

  function automatic logic reg_known(input logic [ADDR_W-1:0] addr);
    return (addr == REG_SWITCH_CFG) || (addr == REG_DETECT_CFG) || (addr == REG_COMMAND)
      || (addr == REG_STATUS) || (addr == REG_EFFECTIVE);
  endfunction : reg_known

  function automatic logic [31:0] merge_strb(input logic [31:0] old,
    input logic [31:0] data, input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[8*b +: 8] = data[8*b +: 8];
    return res & mask;
  endfunction : merge_strb

  function automatic logic check_fault(input psc_test_type mode, input logic err,
    input logic [3:0] cnt);
    case (mode)
      TEST_STRICT: return err;
      TEST_LENIENT: return cnt >= LENIENT_FRAMES; // R18
      default: return 1'b0;
    endcase
  endfunction : check_fault

  function automatic psc_cfg_type remote_cfg(input logic [31:0] sw, input logic [31:0] det);
    psc_cfg_type c;
    c.auto_switch = sw[SW_AUTO_BIT];
    c.auto_revert = sw[SW_REVERT_BIT];
    c.sec_test = sw[SW_SECTEST_BIT];
    c.revert_sec = (sw[SW_HOLD_LSB +: 6] > MAX_REVERT_SEC) ? MAX_REVERT_SEC : sw[SW_HOLD_LSB +: 6];
    c.ovr_mode = psc_ovr_type'(sw[SW_OVR_LSB +: 2]); // R12
    c.trs = psc_test_type'(det[DET_TRS_LSB +: 2]);
    c.edh = psc_test_type'(det[DET_EDH_LSB +: 2]);
    c.audio_en = det[DET_AUD_BIT];
    c.black_en = det[DET_BLK_BIT];
    c.freeze = psc_freeze_type'(det[DET_FRZ_LSB +: 2]);
    c.audio_group = det[DET_GRP_LSB +: 2]; // R13
    c.audio_thr = psc_thr_type'(det[DET_THR_LSB +: 2]); // R14
    c.audio_ch_en = det[DET_CH_LSB +: 4]; // R15
    return c;
  endfunction : remote_cfg

  // bus slave: one write and one read in flight, address and data in any order
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign do_write = (aw_held || aw_take) && (w_held || w_take) && !bvalid;
  assign wr_addr = aw_held ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_held ? wdata_q : s_axi_wdata;
  assign wr_strb = w_held ? wstrb_q : s_axi_wstrb;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  always_comb
  begin
    case (s_axi_araddr)
      REG_SWITCH_CFG: rd_word = sw_word;
      REG_DETECT_CFG: rd_word = det_word;
      REG_STATUS: rd_word = {24'h000000, ready, sec_fault, pri_fault, loaded,
        pins.remote_sel, relay_sec_good, relay_pri_good, relay_sec_selected};
      REG_EFFECTIVE: rd_word = 32'(cfg);
      default: rd_word = 32'h00000000;
    endcase
  end

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_awaddr_q = awaddr_q;
    next_wdata_q = wdata_q;
    next_wstrb_q = wstrb_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (aw_take)
    begin
      next_aw_held = 1'b1;
      next_awaddr_q = s_axi_awaddr;
    end
    if (w_take)
    begin
      next_w_held = 1'b1;
      next_wdata_q = s_axi_wdata;
      next_wstrb_q = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = reg_known(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (ar_take)
    begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awaddr_q <= next_awaddr_q;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // commands act in the cycle the write completes
  assign wr_cmd = do_write && (wr_addr == REG_COMMAND) && wr_strb[0];
  assign cmd_pri = wr_cmd && wr_data[CMD_PRI_BIT];
  assign cmd_sec = wr_cmd && wr_data[CMD_SEC_BIT];
  assign cmd_local = wr_cmd && wr_data[CMD_LOCAL_BIT];
  assign ready = (settle == SETTLE_CYCLES);

  always_comb
  begin
    local_cfg = CFG_DEFAULT; // R10
    local_cfg.trs = pins.local_sw[0] ? TEST_LENIENT : TEST_OFF;
    local_cfg.edh = pins.local_sw[1] ? TEST_LENIENT : TEST_OFF;
    local_cfg.audio_en = pins.local_sw[2];
    local_cfg.black_en = pins.local_sw[3];
    local_cfg.freeze = pins.local_sw[4] ? FRZ_CLEAN : FRZ_OFF;
    local_cfg.auto_revert = pins.local_sw[5];
    next_sw_word = sw_word;
    next_det_word = det_word;
    next_loaded = loaded;
    next_settle = ready ? settle : 2'(settle + 2'h1);
    // stored words survive selector changes; only reset reloads defaults
    if (do_write && (wr_addr == REG_SWITCH_CFG))
    begin
      next_sw_word = merge_strb(sw_word, wr_data, wr_strb, SW_MASK); // R11
      next_loaded = 1'b1;
    end
    if (do_write && (wr_addr == REG_DETECT_CFG))
    begin
      next_det_word = merge_strb(det_word, wr_data, wr_strb, DET_MASK); // R11
      next_loaded = 1'b1;
    end
    if (cmd_local)
      next_loaded = 1'b0;
    if (!ready)
      next_cfg = CFG_DEFAULT; // R20
    else if (pins.remote_sel || loaded) // R08 R09
      next_cfg = remote_cfg(sw_word, det_word);
    else
      next_cfg = local_cfg;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sw_word <= SW_RESET;
      det_word <= DET_RESET;
      loaded <= 1'b0;
      settle <= 2'h0;
      cfg <= CFG_DEFAULT;
    end
    else
    begin
      sw_word <= next_sw_word;
      det_word <= next_det_word;
      loaded <= next_loaded;
      settle <= next_settle;
      cfg <= next_cfg;
    end
  end

  assign det_cfg = cfg;

  // per-input consecutive error-frame counters, index 0 primary, 1 secondary
  for (genvar gi = 0; gi < 2; gi++)
  begin : gen_chk
    logic [3:0] trs_cnt, next_trs_cnt, edh_cnt, next_edh_cnt;
    always_comb
    begin
      next_trs_cnt = trs_cnt;
      next_edh_cnt = edh_cnt;
      if (frame_tick)
      begin
        next_trs_cnt = !trs_err[gi] ? 4'h0
          : (trs_cnt == LENIENT_FRAMES) ? trs_cnt : 4'(trs_cnt + 4'h1); // R18
        next_edh_cnt = !edh_err[gi] ? 4'h0
          : (edh_cnt == LENIENT_FRAMES) ? edh_cnt : 4'(edh_cnt + 4'h1); // R18
      end
    end
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        trs_cnt <= 4'h0;
        edh_cnt <= 4'h0;
      end
      else
      begin
        trs_cnt <= next_trs_cnt;
        edh_cnt <= next_edh_cnt;
      end
    end
    assign input_fault[gi] = check_fault(cfg.trs, trs_err[gi], trs_cnt)
      | check_fault(cfg.edh, edh_err[gi], edh_cnt)
      | (cfg.audio_en & audio_bad[gi]) | (cfg.black_en & black_bad[gi])
      | ((cfg.freeze != FRZ_OFF) & freeze_bad[gi]);
  end

  assign edge_mode = (cfg.ovr_mode == OVR_EDGE); // R12
  assign ext_fault = (cfg.ovr_mode == OVR_FAULT_LOW) && !pins.ovr_level_n[0]; // R12
  assign inhibit = (cfg.ovr_mode == OVR_INHIBIT_LOW) && !pins.ovr_level_n[0]; // R12
  assign pri_fault = input_fault[0] | ext_fault;
  assign sec_fault = input_fault[1] & cfg.sec_test;
  assign force_pri = cmd_pri || (edge_mode && pins.ovr_fall[0]); // R01 R02
  assign force_sec = cmd_sec || (edge_mode && pins.ovr_fall[1]); // R01 R02
  assign revert_due = !pri_fault && (hold_sec >= cfg.revert_sec);

  always_comb
  begin
    next_state = state;
    next_tick_cnt = 24'h000000;
    next_hold_sec = 6'h00;
    case (state)
      SEL_PRI:
        if (ready && !force_pri && force_sec)
          next_state = SEL_SEC; // R02
        else if (ready && !force_pri && cfg.auto_switch && pri_fault && !sec_fault && !inhibit)
          next_state = SEL_SEC; // R16
      SEL_SEC:
      begin
        if (force_pri)
          next_state = SEL_PRI; // R03
        else if (!force_sec && cfg.auto_revert && revert_due)
          next_state = SEL_PRI; // R17
        // hold time restarts at every primary fault
        if (!pri_fault)
        begin
          next_tick_cnt = (tick_cnt == TICK_LAST) ? 24'h000000 : TICK_W'(tick_cnt + 24'h000001);
          next_hold_sec = (tick_cnt == TICK_LAST && hold_sec != MAX_REVERT_SEC)
            ? 6'(hold_sec + 6'h01) : hold_sec;
        end
      end
      default: next_state = SEL_PRI;
    endcase
    next_relay_pri = ready && !pri_fault; // R04 R07
    next_relay_sec = ready && !sec_fault; // R05 R07
    next_alarm = ready && pri_fault; // R16
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= SEL_PRI; // R20
      tick_cnt <= 24'h000000;
      hold_sec <= 6'h00;
      relay_pri_good <= 1'b0;
      relay_sec_good <= 1'b0;
      pri_alarm <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      hold_sec <= next_hold_sec;
      relay_pri_good <= next_relay_pri;
      relay_sec_good <= next_relay_sec;
      pri_alarm <= next_alarm;
    end
  end

  assign relay_sec_selected = (state == SEL_SEC); // R06

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_state: assert property (@(posedge aclk) disable iff (1'b0) // R20
    !aresetn |=> (!relay_pri_good && !relay_sec_good && !relay_sec_selected && !pri_alarm))
    else $error("relays not released after reset");
  a_gpi_sec: assert property ( // R02
    (ready && edge_mode && pins.ovr_fall[1] && !pins.ovr_fall[0] && !cmd_pri)
    |=> relay_sec_selected) else $error("secondary override ignored");
  a_gpi_pri: assert property ( // R03
    (relay_sec_selected && edge_mode && pins.ovr_fall[0]) |=> !relay_sec_selected)
    else $error("primary override did not return to primary");
  a_pri_relay: assert property ( // R04
    (cfg.trs == TEST_STRICT && trs_err[0]) |=> !relay_pri_good)
    else $error("primary relay good while primary faulted");
  a_sec_relay: assert property ( // R05
    (cfg.sec_test && cfg.edh == TEST_STRICT && edh_err[1]) |=> !relay_sec_good)
    else $error("secondary relay good while secondary faulted");
  a_auto_switch: assert property ( // R16
    (state == SEL_PRI && ready && cfg.auto_switch && pri_fault && !sec_fault && !inhibit
    && !force_pri) |=> relay_sec_selected) else $error("auto switch missed");
  a_no_bad_switch: assert property ( // R16
    (state == SEL_PRI && sec_fault && !force_sec) |=> !relay_sec_selected)
    else $error("switched onto a faulted secondary");
  a_revert_cause: assert property ( // R17
    $fell(relay_sec_selected) |-> ($past(force_pri)
    || ($past(cfg.auto_revert) && !$past(pri_fault) && $past(hold_sec) >= $past(cfg.revert_sec))))
    else $error("returned to primary without cause");
  a_lenient_run: assert property ( // R18
    (cfg.trs == TEST_LENIENT && trs_err[0] && frame_tick && gen_chk[0].trs_cnt == 4'h0)
    ##1 (trs_err[0] [*8]) |-> !check_fault(cfg.trs, trs_err[0], gen_chk[0].trs_cnt))
    else $error("lenient check faulted too early");
  a_local_default: assert property ( // R10
    (ready && !pins.remote_sel && !loaded) |=>
    (cfg.audio_group == GROUP_DEF && cfg.audio_ch_en == CH_EN_DEF && cfg.audio_thr == THR_38DB))
    else $error("local mode lost a default value");

  c_auto_switch: cover property ($rose(relay_sec_selected) && !$past(force_sec));
  c_auto_revert: cover property ($fell(relay_sec_selected) && !$past(force_pri));
  c_gpi_edge: cover property (edge_mode && pins.ovr_fall[0] && relay_sec_selected);
  c_lenient_fault: cover property (cfg.trs == TEST_LENIENT && gen_chk[0].trs_cnt == LENIENT_FRAMES);

endmodule : psc_switch_control
`default_nettype wire

// >>> dv/psc_ext_source.sv
// model: external trigger source pulsing the override pins low
`timescale 1ns/1ps
`default_nettype none
module psc_ext_source
#(
  parameter int LOW_CYCLES = 3
)
(
  input wire logic aclk,
  input wire logic [1:0] fire,
  output logic [1:0] ovr_n
);
  int cnt [2] = '{0, 0};
  // shorter pulses could slip past the two-flop synchroniser
  always @(posedge aclk)
    for (int k = 0; k < 2; k++)
      if (fire[k])
      begin
        ovr_n[k] <= 1'h0;
        cnt[k] <= LOW_CYCLES;
      end
      else if (cnt[k] > 1)
        cnt[k] <= cnt[k] - 1;
      else
        ovr_n[k] <= 1'h1;
endmodule : psc_ext_source
`default_nettype wire

// >>> dv/tb_psc_switch_control.sv
// testbench: register bus, override pins and status of the switch control
`timescale 1ns/1ps
`default_nettype none
module tb_psc_switch_control;
  import psc_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, remote_sel = 1'h0, frame_tick = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [5:0] local_sw = 6'h2F;
  logic [1:0] trs_err = 2'h0, edh_err = 2'h0, fire = 2'h0;
  logic [1:0] audio_bad = 2'h0, black_bad = 2'h0, freeze_bad = 2'h0;
  logic [1:0] ovr_n, s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata;
  logic relay_pri_good, relay_sec_good, relay_sec_selected, pri_alarm;
  psc_cfg_type det_cfg, cfg_exp;
  logic [65:0] exp_q[$];
  int error_cnt = 0, n_compared = 0;
  logic [31:0] lfsr = 32'h4992, w;

  psc_switch_control #(.TICKS_PER_SECOND(20)) u_psc_switch_control (.*);
  psc_ext_source u_psc_ext_source (.aclk(aclk), .fire(fire), .ovr_n(ovr_n));

  initial forever #50 aclk = ~aclk;
  // free-running frame pulse keeps lenient counters exercised
  always @(posedge aclk) frame_tick <= ~frame_tick;

  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : step

  task automatic complete_run;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic hang(input string s);
    error_cnt++;
    $display("wrong value at %0t: %s hang", $time, s);
    complete_run();
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    exp_q.push_back({r, 64'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awprot <= lfsr[2:0];
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int i = 0; i <= 40; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
      if (i == 40) hang("write");
    end
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] r);
    @(posedge aclk);
    exp_q.push_back({r, m, e});
    s_axi_araddr <= a;
    s_axi_arprot <= lfsr[5:3];
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (int i = 0; i <= 40; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
      if (i == 40) hang("read");
    end
    s_axi_rready <= 1'h0;
  endtask : rd

  task automatic pulse(input logic [1:0] k);
    @(posedge aclk);
    fire <= k;
    @(posedge aclk);
    fire <= 2'h0;
    repeat (10) @(posedge aclk);
  endtask : pulse

  // relay levels and detector setup are looked at mid-cycle, where they are settled
  task automatic pins_chk(input logic [3:0] e, input psc_cfg_type c);
    @(negedge aclk);
    n_compared++;
    if ({pri_alarm, relay_sec_selected, relay_sec_good, relay_pri_good} !== e || det_cfg !== c)
    begin
      error_cnt++;
      $display("wrong value at %0t: relay outputs or detector setup", $time);
    end
    @(posedge aclk);
  endtask : pins_chk

  always @(posedge aclk)
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready))
    begin
      n_compared++;
      if (exp_q.size() == 0 || (s_axi_rready ? s_axi_rresp : s_axi_bresp) !== exp_q[0][65:64] ||
          (s_axi_rdata & exp_q[0][63:32]) !== exp_q[0][31:0])
      begin
        error_cnt++;
        $display("wrong value at %0t: response or read data %h", $time, s_axi_rdata);
      end
      void'(exp_q.pop_front());
    end

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (8) @(posedge aclk);
    rd(REG_SWITCH_CFG, '1, SW_RESET, RESP_OKAY);
    rd(REG_DETECT_CFG, '1, DET_RESET, RESP_OKAY);
    rd(REG_EFFECTIVE, 32'h07FFFFFF, 32'(CFG_DEFAULT), RESP_OKAY);
    rd(8'h14, '1, 32'h0, RESP_SLVERR);
    rd(REG_STATUS, 32'hFF, 32'h86, RESP_OKAY);
    pins_chk(4'h3, CFG_DEFAULT);
    pulse(2'h2);
    rd(REG_STATUS, 32'h01, 32'h01, RESP_OKAY);
    pulse(2'h1);
    rd(REG_STATUS, 32'h01, 32'h00, RESP_OKAY);
    wr(REG_SWITCH_CFG, 32'h00010F05, RESP_OKAY);
    lfsr = step(lfsr);
    w = (lfsr & 32'hFFF0) | 32'hA;
    wr(REG_DETECT_CFG, w, RESP_OKAY);
    rd(REG_DETECT_CFG, '1, w, RESP_OKAY);
    trs_err <= 2'h1;
    repeat (6) @(posedge aclk);
    rd(REG_STATUS, 32'hFF, 32'hB5, RESP_OKAY);
    trs_err <= 2'h0;
    repeat (100) @(posedge aclk);
    rd(REG_STATUS, 32'hFF, 32'h97, RESP_OKAY);
    pulse(2'h1);
    rd(REG_STATUS, 32'h01, 32'h00, RESP_OKAY);
    {trs_err, edh_err} <= 4'h6;
    repeat (6) @(posedge aclk);
    rd(REG_STATUS, 32'hFF, 32'hF0, RESP_OKAY);
    {trs_err, edh_err} <= 4'h0;
    wr(REG_DETECT_CFG, DET_RESET, RESP_OKAY);
    trs_err <= 2'h1;
    repeat (6) @(posedge aclk);
    rd(REG_STATUS, 32'hFF, 32'h96, RESP_OKAY);
    repeat (30) @(posedge aclk);
    rd(REG_STATUS, 32'hFF, 32'hB5, RESP_OKAY);
    cfg_exp = CFG_DEFAULT;
    cfg_exp.auto_revert = 1'h0;
    pins_chk(4'hE, cfg_exp);
    trs_err <= 2'h0;
    wr(REG_COMMAND, 32'h1, RESP_OKAY);
    rd(REG_STATUS, 32'h01, 32'h00, RESP_OKAY);
    wr(REG_COMMAND, 32'h6, RESP_OKAY);
    rd(REG_STATUS, 32'h11, 32'h01, RESP_OKAY);
    pulse(2'h1);
    rd(REG_STATUS, 32'h01, 32'h00, RESP_OKAY);
    wr(REG_SWITCH_CFG, 32'h00020F05, RESP_OKAY);
    pulse(2'h1);
    rd(REG_STATUS, 32'h21, 32'h01, RESP_OKAY);
    wr(8'h14, 32'h0, RESP_SLVERR);
    complete_run();
  end
endmodule : tb_psc_switch_control
`default_nettype wire
